/* File: ochv_defines.svh */
// Purpose: Offsets, field positions, reset values for the over-current and
//          high-voltage input control block.
// Assumes: Eight-bit registers on a plain strobe port.
// Notes:   Definitions only.
`ifndef OCHV_DEFINES_SVH
`define OCHV_DEFINES_SVH
`define OCHV_ADDR_DET_EN   4'h0
`define OCHV_ADDR_IRQ_EN   4'h1
`define OCHV_ADDR_FLAGS    4'h2
`define OCHV_ADDR_HV_STATE 4'h3
`define OCHV_ADDR_HV_DIEN  4'h4
`define OCHV_ADDR_ANALOG   4'h5
`define OCHV_BIT_SUPPLY    7
`define OCHV_BIT_PIN_A     5
`define OCHV_BIT_PIN_B     3
`define OCHV_BIT_PIN_C     1
`define OCHV_SRC_MASK      8'hAA
`define OCHV_BIT_HV        0
`define OCHV_BIT_AEN       3
`define OCHV_BIT_TEST      7
`define OCHV_ANALOG_MASK   8'h88
`define OCHV_RST_BYTE      8'h00
`define OCHV_RST_HV_DIEN   8'h00
`endif

/* File: ochv_pkg.sv */
// Purpose: Types shared by the over-current and high-voltage input block.
// Assumes: Nothing beyond the defines header.
// Notes:   The register bus travels as one packed request struct.
package ochv_pkg;
  // One register bus request from the master.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ochv_req_t;
endpackage : ochv_pkg

/* File: ochv_ctrl.sv */
// Purpose: Over-current detector control and high-voltage input path.
// Assumes: Detector outputs and pin are asynchronous and are synchronised.
// Notes:   Registers on a strobe port; read data one cycle after the strobe.
// Functional notes
// RULE1: Four detector enables at bits 7,5,3,1.
// RULE2: Interrupt enable bits share detector bit positions.
// RULE3: Cleared interrupt enable masks that source's flag.
// RULE4: Detected over-current sets that source's flag.
// RULE5: Input reads synced pin when digital, not analog.
// RULE6: Otherwise the input register bit reads one.
// RULE7: Digital enable turns the input buffer on.
// RULE8: Analog connection forces buffer off in run.
// RULE9: Stop mode: buffer follows digital enable only.
// RULE10: Software accesses these registers at any time.
// RULE11: Test override keeps buffer on in run.
// RULE12: Analog link wins over digital in run.
// RULE13: Write one clears flag; zero leaves it.
// RULE14: Interrupt high while flag and enable pair.
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "ochv_defines.svh"
module ochv_ctrl (
  input  wire logic              MCLK,
  input  wire logic              RESET,
  input  wire ochv_pkg::ochv_req_t BUS_REQ,
  output logic [7:0]             BUS_RDATA,
  input  wire logic [3:0]        OC_DETECT,
  input  wire logic              HV_PIN,
  input  wire logic              STOP_MODE,
  output logic [3:0]             OC_DET_ENABLE,
  output logic                   HV_BUF_ENABLE,
  output logic                   ANALOG_LINK,
  output logic                   OC_IRQ
);
  import ochv_pkg::*;

  // Software-visible registers.
  logic [7:0] det_en_r;      // Detector enables.
  logic [7:0] irq_en_r;      // Interrupt enables.
  logic [7:0] flags_r;       // Sticky event flags.
  logic [7:0] flags_nxt;     // Next flag value.
  logic [7:0] hv_dien_r;     // Digital input enable.
  logic [7:0] analog_r;      // Analog connection and test override.
  logic [7:0] rdata_r;       // Registered read data.
  // Synchronisers: stage one is read only by stage two.
  logic [3:0] oc_s1_r;       // First stage, detector events.
  logic [3:0] oc_s2_r;       // Second stage, detector events.
  logic       hv_s1_r;       // First stage, pin.
  logic       hv_s2_r;       // Second stage, pin.
  logic       stop_s1_r;     // First stage, stop mode.
  logic       stop_s2_r;     // Second stage, stop mode.

  // Spread four sources onto their byte positions.
  function automatic logic [7:0] spread(input logic [3:0] s);
    spread = {s[3], 1'b0, s[2], 1'b0, s[1], 1'b0, s[0], 1'b0};
  endfunction : spread

  // Address decode as named wires.
  wire wr_det  = BUS_REQ.wr && (BUS_REQ.addr == `OCHV_ADDR_DET_EN);
  wire wr_irq  = BUS_REQ.wr && (BUS_REQ.addr == `OCHV_ADDR_IRQ_EN);
  wire wr_flag = BUS_REQ.wr && (BUS_REQ.addr == `OCHV_ADDR_FLAGS);
  wire wr_dien = BUS_REQ.wr && (BUS_REQ.addr == `OCHV_ADDR_HV_DIEN);
  wire wr_ana  = BUS_REQ.wr && (BUS_REQ.addr == `OCHV_ADDR_ANALOG);

  // Mode terms for the high-voltage pin.
  // All three come straight from registers, so a write reaches the
  // buffer in the cycle after its write strobe.
  wire aen   = analog_r[`OCHV_BIT_AEN];   // Analog link. [RULE12]
  wire tover = analog_r[`OCHV_BIT_TEST];  // Test override of the buffer.
  wire dien  = hv_dien_r[`OCHV_BIT_HV];   // Digital input enable.
  // In run mode analog wins unless the test override holds the buffer on;
  // in stop mode only the digital enable matters.
  // A buffer left on at a mid-rail analog level draws cross-conduction
  // current, which is why the analog link turns it off by default.
  wire buf_on = stop_s2_r ? dien                 // [RULE9]
              : (aen ? tover : dien);            // [RULE7] [RULE8] [RULE11]
  // The input register shows the pin only in plain digital mode.
  wire hv_bit = (dien && !aen) ? hv_s2_r : 1'b1;         // [RULE5] [RULE6]

  // Events only count while their detector is enabled.
  // A level that stays high keeps setting its flag, so software must
  // remove the cause before a clear will stick.
  wire [7:0] events = spread(oc_s2_r) & det_en_r;        // [RULE4]
  // Set wins over a simultaneous write-one clear.
  wire [7:0] clr = wr_flag ? BUS_REQ.wdata : 8'h00;      // [RULE13]
  assign flags_nxt = ((flags_r & ~clr) | events) & `OCHV_SRC_MASK; // [RULE4]

  // Read multiplexer; unmapped addresses read zero.
  // The input register is read-only: no write decode exists for it, so
  // a write there changes nothing.
  wire [7:0] rd_mux =
      (BUS_REQ.addr == `OCHV_ADDR_DET_EN)   ? det_en_r  :
      (BUS_REQ.addr == `OCHV_ADDR_IRQ_EN)   ? irq_en_r  :
      (BUS_REQ.addr == `OCHV_ADDR_FLAGS)    ? flags_r   :
      (BUS_REQ.addr == `OCHV_ADDR_HV_STATE) ? {7'h00, hv_bit} :
      (BUS_REQ.addr == `OCHV_ADDR_HV_DIEN)  ? hv_dien_r :
      (BUS_REQ.addr == `OCHV_ADDR_ANALOG)   ? analog_r  : 8'h00;

  // Synchronisers for asynchronous inputs.
  // Two stages trade two cycles of latency for a metastability margin
  // that suits a 50 MHz clock.
  always_ff @(posedge MCLK)
  begin
    // Reset clears both stages, so no false event follows reset.
    if (RESET)
    begin
      oc_s1_r   <= 4'h0;
      oc_s2_r   <= 4'h0;
      hv_s1_r   <= 1'b0;
      hv_s2_r   <= 1'b0;
      stop_s1_r <= 1'b0;
      stop_s2_r <= 1'b0;
    end
    else
    begin
      // Stage two copies stage one; only stage two feeds the logic.
      oc_s1_r   <= OC_DETECT;
      oc_s2_r   <= oc_s1_r;
      hv_s1_r   <= HV_PIN;
      hv_s2_r   <= hv_s1_r;
      stop_s1_r <= STOP_MODE;
      stop_s2_r <= stop_s1_r;
    end
  end

  // Register writes; any writable register may be written at any time.
  always_ff @(posedge MCLK)
  begin
    // All registers return to zero.
    if (RESET)
    begin
      det_en_r  <= `OCHV_RST_BYTE;
      irq_en_r  <= `OCHV_RST_BYTE;
      flags_r   <= `OCHV_RST_BYTE;
      hv_dien_r <= `OCHV_RST_HV_DIEN;
      analog_r  <= `OCHV_RST_BYTE;
    end
    else
    begin
      // Only the four source positions hold a detector enable.
      if (wr_det)
        det_en_r <= BUS_REQ.wdata & `OCHV_SRC_MASK;      // [RULE1] [RULE10]
      // Interrupt enables use the same four positions.
      if (wr_irq)
        irq_en_r <= BUS_REQ.wdata & `OCHV_SRC_MASK;      // [RULE2] [RULE10]
      // The digital enable has a single bit at position zero.
      if (wr_dien)
        hv_dien_r <= {7'h00, BUS_REQ.wdata[`OCHV_BIT_HV]}; // [RULE10]
      // Only the analog link and the test override are kept.
      if (wr_ana)
        analog_r <= BUS_REQ.wdata & `OCHV_ANALOG_MASK;   // [RULE12]
      // Flags update every cycle: events set, written ones clear.
      flags_r <= flags_nxt;                              // [RULE13]
    end
  end

  // Read data stands only in the cycle after the read strobe.
  // Returning zero between reads keeps stale data off the bus.
  always_ff @(posedge MCLK)
  begin
    // Nothing is read during reset.
    if (RESET)
      rdata_r <= 8'h00;
    // Capture the selected register on a read strobe, else zero.
    else
      rdata_r <= BUS_REQ.rd ? rd_mux : 8'h00;
  end

  // Outputs: read data, detector enables in source order, buffer and link.
  assign BUS_RDATA     = rdata_r;
  assign OC_DET_ENABLE = {det_en_r[`OCHV_BIT_SUPPLY],          // [RULE1]
                          det_en_r[`OCHV_BIT_PIN_A],
                          det_en_r[`OCHV_BIT_PIN_B],
                          det_en_r[`OCHV_BIT_PIN_C]};
  assign HV_BUF_ENABLE = buf_on;
  assign ANALOG_LINK   = aen;
  // A cleared enable masks its flag from the request.
  assign OC_IRQ        = |(flags_r & irq_en_r);          // [RULE3] [RULE14]

  // A detected enabled event shows in the flag one edge later.
  a_flag_sets: assert property ( // [RULE4]
    @(posedge MCLK) disable iff (RESET)
    (events != 8'h00) |=> ((flags_r & $past(events)) == $past(events)))
    else $error("Enabled event did not set its flag.");

  // A write of one clears a flag with no event pending.
  a_flag_clears: assert property ( // [RULE13]
    @(posedge MCLK) disable iff (RESET)
    (wr_flag && BUS_REQ.wdata[7] && !events[7]) |=> !flags_r[7])
    else $error("Write-one did not clear the flag.");

  // Writing zero never clears a flag.
  a_zero_keeps: assert property ( // [RULE13]
    @(posedge MCLK) disable iff (RESET)
    (flags_r[5] && !(wr_flag && BUS_REQ.wdata[5])) |=> flags_r[5])
    else $error("Flag dropped without a write of one.");

  // The interrupt follows enabled flag pairs, source by source.
  a_irq_pair: assert property ( // [RULE14]
    @(posedge MCLK) disable iff (RESET)
    OC_IRQ == ((flags_r[7] && irq_en_r[7]) || (flags_r[5] && irq_en_r[5]) ||
               (flags_r[3] && irq_en_r[3]) || (flags_r[1] && irq_en_r[1])))
    else $error("Interrupt does not match flag and enable.");

  // A masked flag alone raises no interrupt.
  a_irq_mask: assert property ( // [RULE3]
    @(posedge MCLK) disable iff (RESET)
    (irq_en_r == 8'h00) |-> !OC_IRQ)
    else $error("Interrupt raised with all sources masked.");

  // The input register reads one outside plain digital mode.
  a_hv_one: assert property ( // [RULE6]
    @(posedge MCLK) disable iff (RESET)
    (BUS_REQ.rd && BUS_REQ.addr == `OCHV_ADDR_HV_STATE && (aen || !dien))
    |=> BUS_RDATA == 8'h01)
    else $error("Input register did not read one.");

  // In plain digital mode the read shows the synchronised pin.
  a_hv_pin: assert property ( // [RULE5]
    @(posedge MCLK) disable iff (RESET)
    (BUS_REQ.rd && BUS_REQ.addr == `OCHV_ADDR_HV_STATE && dien && !aen)
    |=> BUS_RDATA == {7'h00, $past(hv_s2_r)})
    else $error("Input register did not show the pin.");

  // Analog use in run mode turns the buffer off unless overridden.
  a_buf_run: assert property ( // [RULE8]
    @(posedge MCLK) disable iff (RESET)
    (!stop_s2_r && aen) |-> (HV_BUF_ENABLE == tover))
    else $error("Run-mode analog buffer control wrong.");

  // Stop mode leaves the buffer to the digital enable.
  a_buf_stop: assert property ( // [RULE9]
    @(posedge MCLK) disable iff (RESET)
    stop_s2_r |-> (HV_BUF_ENABLE == dien))
    else $error("Stop-mode buffer control wrong.");

  // A written detector enable appears on its output next cycle.
  a_det_write: assert property ( // [RULE1]
    @(posedge MCLK) disable iff (RESET)
    wr_det |=> (OC_DET_ENABLE[3] == $past(BUS_REQ.wdata[7])))
    else $error("Detector enable write lost.");

  // An enabled, synchronised supply detector level sets its flag.
  a_supply_event: assert property ( // [RULE4]
    @(posedge MCLK) disable iff (RESET)
    (oc_s2_r[3] && det_en_r[`OCHV_BIT_SUPPLY])
    |=> flags_r[`OCHV_BIT_SUPPLY])
    else $error("Supply over-current did not set its flag.");

  // A disabled detector never raises a clear flag.
  a_event_off: assert property ( // [RULE1]
    @(posedge MCLK) disable iff (RESET)
    (!det_en_r[`OCHV_BIT_SUPPLY] && !flags_r[`OCHV_BIT_SUPPLY])
    |=> !flags_r[`OCHV_BIT_SUPPLY])
    else $error("Flag set with its detector disabled.");

  // A flag with its enable set always requests an interrupt.
  a_pin_c_irq: assert property ( // [RULE14]
    @(posedge MCLK) disable iff (RESET)
    (flags_r[`OCHV_BIT_PIN_C] && irq_en_r[`OCHV_BIT_PIN_C]) |-> OC_IRQ)
    else $error("Enabled flag raised no interrupt.");

  // Positions without a source stay zero in all three source registers.
  a_reserved_zero: assert property ( // [RULE4]
    @(posedge MCLK) disable iff (RESET)
    ((flags_r | det_en_r | irq_en_r) & ~`OCHV_SRC_MASK) == 8'h00)
    else $error("Reserved source bit set.");

  // Read data is zero in any cycle that follows no read strobe.
  a_rdata_idle: assert property (
    @(posedge MCLK) disable iff (RESET)
    !BUS_REQ.rd |=> (BUS_RDATA == 8'h00))
    else $error("Read data stood without a read.");

  // A flag read returns the flags as they stood at the strobe.
  a_flag_read: assert property ( // [RULE13]
    @(posedge MCLK) disable iff (RESET)
    (BUS_REQ.rd && BUS_REQ.addr == `OCHV_ADDR_FLAGS)
    |=> (BUS_RDATA == $past(flags_r)))
    else $error("Flag read returned wrong data.");

  // A write of the digital enable reaches the buffer control.
  a_dien_write: assert property ( // [RULE7]
    @(posedge MCLK) disable iff (RESET)
    wr_dien |=> (dien == $past(BUS_REQ.wdata[`OCHV_BIT_HV])))
    else $error("Digital enable write lost.");

  // A write of the analog control reaches the link output.
  a_link_write: assert property ( // [RULE12]
    @(posedge MCLK) disable iff (RESET)
    wr_ana |=> (ANALOG_LINK == $past(BUS_REQ.wdata[`OCHV_BIT_AEN])))
    else $error("Analog link write lost.");

  // Without the analog link, run mode follows the digital enable.
  a_buf_digital: assert property ( // [RULE7]
    @(posedge MCLK) disable iff (RESET)
    (!stop_s2_r && !aen) |-> (HV_BUF_ENABLE == dien))
    else $error("Run-mode digital buffer control wrong.");

  // A write of the interrupt enables keeps only the source positions.
  a_ien_write: assert property ( // [RULE2]
    @(posedge MCLK) disable iff (RESET)
    wr_irq |=> (irq_en_r == ($past(BUS_REQ.wdata) & `OCHV_SRC_MASK)))
    else $error("Interrupt enable write wrong.");

  // A write to the read-only input register changes neither the digital enable nor the analog control.
  a_state_ro: assert property ( // [RULE5]
    @(posedge MCLK) disable iff (RESET)
    (BUS_REQ.wr && BUS_REQ.addr == `OCHV_ADDR_HV_STATE)
    |=> ((hv_dien_r == $past(hv_dien_r)) && (analog_r == $past(analog_r))))
    else $error("Write to the input register changed state.");
endmodule : ochv_ctrl

/* File: ochv_far_model.sv */
// Purpose: Far-side model of the over-current detectors and the pin.
// Assumes: The bench asks for events by holding fire high.
// Notes:   Outputs change on the clock, like slow analog comparators.
`timescale 1ns/1ps
module ochv_far_model (
  input  wire logic       MCLK,
  input  wire logic [3:0] fire,
  input  wire logic       pin_lvl,
  output logic [3:0]      OC_DETECT,
  output logic            HV_PIN
);
  // Detector levels and the pin follow the request one cycle late.
  // The extra cycle mimics comparator settling, so the bench must not
  // expect flags on the first edge.
  always_ff @(posedge MCLK)
  begin
    OC_DETECT <= fire;
    HV_PIN    <= pin_lvl;
  end
endmodule : ochv_far_model

/* File: testbench.sv */
// Purpose: Self-checking bench for the over-current and input control.
// Assumes: Strobe bus, read data in the cycle after the read strobe.
// Notes:   Port checks wait 1 ns after an edge so the edge's updates land.
`timescale 1ns/1ps
`include "ochv_defines.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module testbench;
  import ochv_pkg::*;
  logic MCLK, RESET, pin, stop, irq, buf_en, link;
  logic [3:0] fire, det, oc_det;
  logic [7:0] rdata, d;
  ochv_req_t  req;
  int         fails = 0, checks = 0, i;
  logic       hv;
  ochv_far_model ochv_far_model_inst (.MCLK(MCLK), .fire(fire),
    .pin_lvl(pin), .OC_DETECT(det), .HV_PIN(hv));
  ochv_ctrl ochv_ctrl_inst (.MCLK(MCLK), .RESET(RESET), .BUS_REQ(req),
    .BUS_RDATA(rdata), .OC_DETECT(det), .HV_PIN(hv), .STOP_MODE(stop),
    .OC_DET_ENABLE(oc_det), .HV_BUF_ENABLE(buf_en), .ANALOG_LINK(link),
    .OC_IRQ(irq));
  // Free-running 50 MHz clock.
  initial
  begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end
  // One-cycle write strobe; the register updates at the sampling edge.
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge MCLK) req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge MCLK) req.wr <= 1'b0;
    #1;
  endtask : wr
  // One-cycle read strobe; data is taken in the following cycle only.
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge MCLK) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge MCLK) req.rd <= 1'b0;
    #1 v = rdata;
  endtask : rd
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  // Guards against a hung handshake; the tests need about 110 cycles.
  initial
  begin
    repeat (3000) @(posedge MCLK);
    fails++;
    final_report();
  end
  // Main sequence of register calls and expected values.
  initial
  begin
    req   = '0;
    fire  = 4'h0;
    pin   = 1'b0;
    stop  = 1'b0;
    RESET = 1'b1;
    repeat (5) @(posedge MCLK);
    RESET <= 1'b0;
    // Registers read zero after reset; the input register reads one
    // because the digital enable starts clear.
    for (i = 0; i < 8; i++)
    begin
      rd(i[3:0], d);
      if (i == `OCHV_ADDR_HV_STATE)
        `CHK("reset_hv", 8'h01, d)
      else
        `CHK("reset", 8'h00, d)
    end
    wr(`OCHV_ADDR_DET_EN, 8'hFF);
    `CHK("det", 4'hF, oc_det)
    rd(`OCHV_ADDR_DET_EN, d);
    `CHK("det_rd", 8'hAA, d)
    wr(`OCHV_ADDR_IRQ_EN, 8'hFF);
    rd(`OCHV_ADDR_IRQ_EN, d);
    `CHK("ien_rd", 8'hAA, d)
    wr(`OCHV_ADDR_IRQ_EN, 8'h80);
    `CHK("irq0", 1'b0, irq)
    // Fire all four detectors well past the model and sync latency.
    @(posedge MCLK) fire <= 4'hF;
    repeat (4) @(posedge MCLK);
    fire <= 4'h0;
    repeat (6) @(posedge MCLK);
    rd(`OCHV_ADDR_FLAGS, d);
    `CHK("flags", 8'hAA, d)
    `CHK("irq1", 1'b1, irq)
    wr(`OCHV_ADDR_IRQ_EN, 8'h00);
    `CHK("mask", 1'b0, irq)
    wr(`OCHV_ADDR_FLAGS, 8'h80);
    wr(`OCHV_ADDR_FLAGS, 8'h00);
    rd(`OCHV_ADDR_FLAGS, d);
    `CHK("w1c", 8'h2A, d)
    wr(`OCHV_ADDR_IRQ_EN, 8'h80);
    `CHK("irq_clr", 1'b0, irq)
    wr(`OCHV_ADDR_IRQ_EN, 8'h20);
    `CHK("irq_a", 1'b1, irq)
    wr(`OCHV_ADDR_FLAGS, 8'h2A);
    `CHK("irq_off", 1'b0, irq)
    wr(`OCHV_ADDR_DET_EN, 8'h00);
    `CHK("det_off", 4'h0, oc_det)
    @(posedge MCLK) fire <= 4'hF;
    repeat (8) @(posedge MCLK);
    fire <= 4'h0;
    rd(`OCHV_ADDR_FLAGS, d);
    `CHK("off", 8'h00, d)
    // The pin reads through only in digital mode; one otherwise.
    wr(`OCHV_ADDR_HV_DIEN, 8'h01);
    `CHK("buf", 1'b1, buf_en)
    wr(`OCHV_ADDR_HV_STATE, 8'hFF);
    rd(`OCHV_ADDR_HV_STATE, d);
    `CHK("pin0", 8'h00, d)
    @(posedge MCLK) pin <= 1'b1;
    repeat (5) @(posedge MCLK);
    rd(`OCHV_ADDR_HV_STATE, d);
    `CHK("pin1", 8'h01, d)
    @(posedge MCLK) pin <= 1'b0;
    wr(`OCHV_ADDR_ANALOG, 8'h08);
    repeat (5) @(posedge MCLK);
    rd(`OCHV_ADDR_HV_STATE, d);
    `CHK("ana", 8'h01, d)
    `CHK("link", 1'b1, link)
    `CHK("forced", 1'b0, buf_en)
    wr(`OCHV_ADDR_ANALOG, 8'h88);
    `CHK("ovr", 1'b1, buf_en)
    wr(`OCHV_ADDR_ANALOG, 8'h08);
    @(posedge MCLK) stop <= 1'b1;
    repeat (4) @(posedge MCLK);
    #1;
    `CHK("stop1", 1'b1, buf_en)
    wr(`OCHV_ADDR_HV_DIEN, 8'h00);
    `CHK("stop0", 1'b0, buf_en)
    wr(`OCHV_ADDR_ANALOG, 8'h88);
    `CHK("stop_ovr", 1'b0, buf_en)
    final_report();
  end
endmodule : testbench
